// ===== hw/blr_regs.vh
`ifndef BLR_REGS_VH
`define BLR_REGS_VH

// Register indices; the byte address is four times the index
`define BLR_IDX_BEEP        10'h123
`define BLR_IDX_SUBLPF      10'h124
`define BLR_IDX_DELAY       10'h126
`define BLR_IDX_CONV        10'h127
`define BLR_IDX_FLOW        10'h128
`define BLR_IDX_STATUS      10'h129

// Writable bit masks; everything else is reserved and reads as zero
`define BLR_MASK_BEEP       16'h0F3F
`define BLR_MASK_SUBLPF     16'h000F
`define BLR_MASK_DELAY      16'h0FFF
`define BLR_MASK_CONV       16'h003F
`define BLR_MASK_FLOW       16'h0210

// Reset values
`define BLR_RST_BEEP        16'h0005
`define BLR_RST_SUBLPF      16'h0003
`define BLR_RST_DELAY       16'h0000
`define BLR_RST_CONV        16'h0030
`define BLR_RST_FLOW        16'h0000

// Field positions
`define BLR_BEEP_VOL_HI     11
`define BLR_BEEP_VOL_LO     8
`define BLR_BEEP_FREQ_HI    5
`define BLR_BEEP_FREQ_LO    0
`define BLR_LPF_CUT_HI      3
`define BLR_LPF_CUT_LO      0
`define BLR_DELAY_HI        11
`define BLR_DELAY_LO        0
`define BLR_CONV1_DEEMPH    5
`define BLR_CONV2_DEEMPH    4
`define BLR_CONV1_MUTE_OFF  3
`define BLR_CONV2A_MUTE_OFF 2
`define BLR_FLOW_BEEP_ONLY  9
`define BLR_FLOW_SUB_LPF_OFF 4

// Scaling figures
`define BLR_DELAY_MAX       12'h7E1
`define BLR_TONE_STEP_DHZ   17'h0753
`define BLR_CUT_STEP_HZ     9'h014
`define BLR_CUT_BASE_HZ     9'h028
`define BLR_ATT_BASE_DB     6'h28

// AXI responses
`define BLR_RESP_OKAY       2'h0
`define BLR_RESP_SLVERR     2'h2

`endif

// ===== hw/blr_ctrl_regs.v
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
// How it works
// - Volume bits 11:8, 0 silent, -38..-10 dB
// - Frequency bits 5:0, code times 187.5 Hz
// - Beeper register resets to 0x0005
// - Cutoff bits 3:0, 0 off, 60..340 Hz
// - Subwoofer filter register resets to 0x0003
// - Delay code N gives N+1 samples
// - Code 0x7E1 gives 2018 samples, maximum
// - Delay register resets to zero
// - Enabled converter with error and mute mutes
// - Bit 5 enables first converter de-emphasis
// - Bit 4 enables second converter de-emphasis
// - Bit 3 set disables first converter mute
// - Bits 2..0 disable second converter A/B/C mute
// - Converter control register resets to 0x0030
// - Flow bit 9 selects beeper only on main
// - Flow bit 4 set disables subwoofer filter
`include "blr_regs.vh"

module blr_ctrl_regs #(
    parameter ADDR_W  = 12,
    parameter SMP_W   = 24,
    parameter AUD_W   = 16,
    parameter DLY_AW  = 11
) (
    input  wire                 ref_clk,
    input  wire                 rst_n,
    input  wire [ADDR_W-1:0]    s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [ADDR_W-1:0]    s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire                 first_rate_converter_en,
    input  wire                 first_rate_converter_err,
    input  wire [2:0]           second_rate_converter_en,
    input  wire [2:0]           second_rate_converter_err,
    input  wire                 sample_stb,
    input  wire [SMP_W-1:0]     conv_path_in,
    output reg  [SMP_W-1:0]     conv_path_out,
    input  wire signed [AUD_W-1:0] main_in,
    input  wire signed [AUD_W-1:0] tone_in,
    output reg  signed [AUD_W-1:0] main_out,
    output reg                  beeper_on,
    output reg  [5:0]           beeper_atten_db,
    output reg  [16:0]          beeper_freq_dhz,
    output reg                  sub_lpf_on,
    output reg  [8:0]           subwoofer_filter_cutoff_hz,
    output reg  [11:0]          conv_delay_samples,
    output reg                  first_rate_converter_deemph,
    output reg                  second_rate_converter_deemph,
    output reg                  first_rate_converter_mute,
    output reg  [2:0]           second_rate_converter_mute
);

    // One-hot register select: beep, sublpf, delay, conv, flow, status
    function [5:0] reg_sel;
        input [ADDR_W-1:0] addr;
        begin
            reg_sel = 6'h00;
            if (addr[1:0] == 2'h0) begin
                case (addr[ADDR_W-1:2])
                    `BLR_IDX_BEEP:   reg_sel = 6'h01;
                    `BLR_IDX_SUBLPF: reg_sel = 6'h02;
                    `BLR_IDX_DELAY:  reg_sel = 6'h04;
                    `BLR_IDX_CONV:   reg_sel = 6'h08;
                    `BLR_IDX_FLOW:   reg_sel = 6'h10;
                    `BLR_IDX_STATUS: reg_sel = 6'h20;
                    default:         reg_sel = 6'h00;
                endcase
            end
        end
    endfunction

    // Byte-lane merge, then drop reserved bits
    function [15:0] merge;
        input [15:0] old;
        input [15:0] wdat;
        input [1:0]  strb;
        input [15:0] mask;
        begin
            merge = {strb[1] ? wdat[15:8] : old[15:8],
                     strb[0] ? wdat[7:0]  : old[7:0]} & mask;
        end
    endfunction

    reg [15:0]       beep_q;
    reg [15:0]       sublpf_q;
    reg [15:0]       delay_q;
    reg [15:0]       conv_q;
    reg [15:0]       flow_q;
    reg              aw_held_q;
    reg              w_held_q;
    reg [ADDR_W-1:0] awaddr_q;
    reg [15:0]       wdata_q;
    reg [1:0]        wstrb_q;
    reg              aw_held_d;
    reg              w_held_d;
    reg [15:0]       rd_val;
    reg [15:0]       status_val;
    reg [11:0]       dly_eff;
    reg [AUD_W:0]    mix_sum;
    reg [AUD_W-1:0]  mix_sat;
    reg [DLY_AW-1:0] wptr_q;
    reg [11:0]       fill_q;
    reg [SMP_W-1:0]  dly_mem [0:(1<<DLY_AW)-1];

    wire       aw_take = s_axi_awvalid & s_axi_awready;
    wire       w_take  = s_axi_wvalid & s_axi_wready;
    wire       wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire [5:0] wr_sel  = reg_sel(awaddr_q);
    wire [5:0] rd_sel  = reg_sel(s_axi_araddr);
    wire [3:0] vol     = beep_q[`BLR_BEEP_VOL_HI:`BLR_BEEP_VOL_LO];
    wire [5:0] freq    = beep_q[`BLR_BEEP_FREQ_HI:`BLR_BEEP_FREQ_LO];
    wire [3:0] cut     = sublpf_q[`BLR_LPF_CUT_HI:`BLR_LPF_CUT_LO];
    wire       tone_en = (vol != 4'h0) & (freq != 6'h00);
    wire [DLY_AW-1:0] rd_ptr = wptr_q - dly_eff[DLY_AW-1:0] - {{(DLY_AW-1){1'b0}}, 1'b1};
    wire [2:0]        lane_mute_d;

    // Each second-converter lane mutes on its own; lane 2 is channel A
    genvar ln;
    generate
        for (ln = 0; ln < 3; ln = ln + 1) begin : g_lane
            assign lane_mute_d[ln] = second_rate_converter_en[ln] &
                                     second_rate_converter_err[ln] &
                                     ~conv_q[ln];
        end
    endgenerate

    // Address and data latch apart, so either channel may arrive first
    always @* begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        if (aw_take) begin
            aw_held_d = 1'b1;
        end
        if (w_take) begin
            w_held_d = 1'b1;
        end
        if (wr_fire) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= {ADDR_W{1'b0}};
            wdata_q       <= 16'h0000;
            wstrb_q       <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BLR_RESP_OKAY;
        end else begin
            aw_held_q     <= aw_held_d;
            w_held_q      <= w_held_d;
            s_axi_awready <= ~aw_held_d;
            s_axi_wready  <= ~w_held_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata[15:0];
                wstrb_q <= s_axi_wstrb[1:0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == 6'h00) ? `BLR_RESP_SLVERR : `BLR_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register storage; status is read-only and writes to it are dropped
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            beep_q   <= `BLR_RST_BEEP;
            sublpf_q <= `BLR_RST_SUBLPF;
            delay_q  <= `BLR_RST_DELAY;
            conv_q   <= `BLR_RST_CONV;
            flow_q   <= `BLR_RST_FLOW;
        end else if (wr_fire) begin
            // Masking protects the fields even if software breaks the zero-write habit
            if (wr_sel[0]) begin
                beep_q <= merge(beep_q, wdata_q, wstrb_q, `BLR_MASK_BEEP);
            end
            if (wr_sel[1]) begin
                sublpf_q <= merge(sublpf_q, wdata_q, wstrb_q, `BLR_MASK_SUBLPF);
            end
            if (wr_sel[2]) begin
                delay_q <= merge(delay_q, wdata_q, wstrb_q, `BLR_MASK_DELAY);
            end
            if (wr_sel[3]) begin
                conv_q <= merge(conv_q, wdata_q, wstrb_q, `BLR_MASK_CONV);
            end
            if (wr_sel[4]) begin
                flow_q <= merge(flow_q, wdata_q, wstrb_q, `BLR_MASK_FLOW);
            end
        end
    end

    // Read mux
    always @* begin
        status_val = {8'h00, second_rate_converter_mute, first_rate_converter_mute,
                      second_rate_converter_err, first_rate_converter_err};
        case (rd_sel)
            6'h01:   rd_val = beep_q;
            6'h02:   rd_val = sublpf_q;
            6'h04:   rd_val = delay_q;
            6'h08:   rd_val = conv_q;
            6'h10:   rd_val = flow_q;
            6'h20:   rd_val = status_val;
            default: rd_val = 16'h0000;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `BLR_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, rd_val};
                s_axi_rresp   <= (rd_sel == 6'h00) ? `BLR_RESP_SLVERR : `BLR_RESP_OKAY;
            end else if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid  <= 1'b0;
                    s_axi_arready <= 1'b1;
                end
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Codes above the documented top are held at 2018 samples so the ring never wraps short
    always @* begin
        dly_eff = delay_q[`BLR_DELAY_HI:`BLR_DELAY_LO];
        if (dly_eff > `BLR_DELAY_MAX) begin
            dly_eff = `BLR_DELAY_MAX;
        end
    end

    // Beeper mixing with saturation rather than wrap, to avoid loud clicks
    always @* begin
        mix_sum = {main_in[AUD_W-1], main_in} + {tone_in[AUD_W-1], tone_in};
        if (mix_sum[AUD_W] != mix_sum[AUD_W-1]) begin
            mix_sat = {mix_sum[AUD_W], {(AUD_W-1){~mix_sum[AUD_W]}}};
        end else begin
            mix_sat = mix_sum[AUD_W-1:0];
        end
    end

    // Converter-path delay ring: output at each strobe is the input from N+1 strobes back
    always @(posedge ref_clk) begin
        if (sample_stb) begin
            dly_mem[wptr_q] <= conv_path_in;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q        <= {DLY_AW{1'b0}};
            conv_path_out <= {SMP_W{1'b0}};
        end else if (sample_stb) begin
            wptr_q <= wptr_q + {{(DLY_AW-1){1'b0}}, 1'b1};
            if (fill_q > dly_eff) begin
                conv_path_out <= dly_mem[rd_ptr];
            end else begin
                conv_path_out <= {SMP_W{1'b0}};
            end
        end
    end

    // Until the ring holds N+1 samples the output stays zero rather than stale memory
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_q <= 12'h000;
        end else if (sample_stb && (fill_q != 12'hFFF)) begin
            fill_q <= fill_q + 12'h001;
        end
    end

    // Main channel mix, kept apart from the slow control decodes
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_out <= {AUD_W{1'b0}};
        end else if (flow_q[`BLR_FLOW_BEEP_ONLY]) begin
            main_out <= tone_en ? tone_in : {AUD_W{1'b0}};
        end else begin
            main_out <= tone_en ? mix_sat : main_in;
        end
    end

    // Decoded controls, all registered
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            beeper_on                    <= 1'b0;
            beeper_atten_db              <= 6'h00;
            beeper_freq_dhz              <= 17'h00000;
            sub_lpf_on                   <= 1'b0;
            subwoofer_filter_cutoff_hz   <= 9'h000;
            conv_delay_samples           <= 12'h000;
            first_rate_converter_deemph  <= 1'b0;
            second_rate_converter_deemph <= 1'b0;
            first_rate_converter_mute    <= 1'b0;
            second_rate_converter_mute   <= 3'h0;
        end else begin
            beeper_on       <= tone_en;
            beeper_atten_db <= (vol == 4'h0) ? 6'h00 : `BLR_ATT_BASE_DB - {1'b0, vol, 1'b0};
            beeper_freq_dhz <= {11'h000, freq} * `BLR_TONE_STEP_DHZ;
            sub_lpf_on      <= (cut != 4'h0) & ~flow_q[`BLR_FLOW_SUB_LPF_OFF];
            subwoofer_filter_cutoff_hz <= (cut == 4'h0) ? 9'h000 :
                                          {5'h00, cut} * `BLR_CUT_STEP_HZ + `BLR_CUT_BASE_HZ;
            conv_delay_samples <= dly_eff + 12'h001;
            first_rate_converter_deemph  <= conv_q[`BLR_CONV1_DEEMPH];
            second_rate_converter_deemph <= conv_q[`BLR_CONV2_DEEMPH];
            first_rate_converter_mute <= first_rate_converter_en & first_rate_converter_err &
                                         ~conv_q[`BLR_CONV1_MUTE_OFF];
            second_rate_converter_mute <= lane_mute_d;
        end
    end

endmodule // blr_ctrl_regs

// ===== bench/blr_ctrl_properties.sv
`timescale 1ns/1ns
module blr_ctrl_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        beeper_on,
    input wire logic [5:0]  beeper_atten_db,
    input wire logic [16:0] beeper_freq_dhz,
    input wire logic [8:0]  subwoofer_filter_cutoff_hz,
    input wire logic [11:0] conv_delay_samples,
    input wire logic        first_rate_converter_en,
    input wire logic        first_rate_converter_err,
    input wire logic        first_rate_converter_mute,
    input wire logic [2:0]  second_rate_converter_en,
    input wire logic [2:0]  second_rate_converter_err,
    input wire logic [2:0]  second_rate_converter_mute
);
    // Decoded outputs are only meaningful from the second edge after reset
    logic live_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) live_q <= 1'b0;
        else live_q <= 1'b1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    rd_answer_a: assert property (rd_take |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    atten_step_a: assert property (live_q && beeper_atten_db != 6'h00 |->
        beeper_atten_db inside {[10:38]} && !beeper_atten_db[0]) else $error("bad attenuation");
    tone_gate_a: assert property (live_q |-> beeper_on ==
        (beeper_atten_db != 6'h00 && beeper_freq_dhz != 17'h00000)) else $error("bad tone gate");
    freq_step_a: assert property (live_q |-> beeper_freq_dhz % 1875 == 0
        && beeper_freq_dhz <= 118125) else $error("bad tone frequency");
    cutoff_step_a: assert property (live_q && subwoofer_filter_cutoff_hz != 9'h000 |->
        subwoofer_filter_cutoff_hz inside {[60:340]} && subwoofer_filter_cutoff_hz % 20 == 0)
        else $error("bad cutoff");
    delay_span_a: assert property (live_q |-> conv_delay_samples inside {[1:2018]})
        else $error("bad delay");
    mute_cause_a: assert property (first_rate_converter_mute |->
        $past(first_rate_converter_en && first_rate_converter_err)) else $error("stray mute");
    mute_lanes_a: assert property ((second_rate_converter_mute &
        ~$past(second_rate_converter_en & second_rate_converter_err)) == 3'h0)
        else $error("stray lane mute");
endmodule // blr_ctrl_props

bind blr_ctrl_regs blr_ctrl_props blr_ctrl_props_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .beeper_on(beeper_on), .beeper_atten_db(beeper_atten_db), .beeper_freq_dhz(beeper_freq_dhz),
    .subwoofer_filter_cutoff_hz(subwoofer_filter_cutoff_hz), .conv_delay_samples(conv_delay_samples),
    .first_rate_converter_en(first_rate_converter_en), .first_rate_converter_err(first_rate_converter_err),
    .first_rate_converter_mute(first_rate_converter_mute), .second_rate_converter_en(second_rate_converter_en),
    .second_rate_converter_err(second_rate_converter_err),
    .second_rate_converter_mute(second_rate_converter_mute));

// ===== bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {logic [11:0] a; logic [15:0] d; logic [15:0] e; logic [1:0] r;} blr_row_t;
    logic               ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0, stb = 0;
    logic               en1 = 0, er1 = 0;
    logic [2:0]         en2 = 0, er2 = 0;
    logic [11:0]        awaddr = 0, araddr = 0;
    logic [31:0]        wdata = 0, g;
    logic [23:0]        pin = 0;
    logic signed [15:0] mi = 0, ti = 0;
    logic [1:0]         r;
    logic [3:0]         strb = 4'h3;
    wire                awready, wready, bvalid, arready, rvalid, on, d1, d2, m1, lpf_on;
    wire [1:0]          bresp, rresp;
    wire [31:0]         rdata;
    wire [23:0]         pout;
    wire signed [15:0]  mo;
    wire [5:0]          att;
    wire [16:0]         fq;
    wire [8:0]          hz;
    wire [11:0]         dly;
    wire [2:0]          m2;
    int                 miscompares = 0, n_compared = 0;
    // Reserved bits are written as ones on purpose to see that they read back as zero
    blr_row_t rows [7] = '{'{12'h48C, 16'hFFFF, 16'h0F3F, 2'h0}, '{12'h490, 16'hFFFF, 16'h000F, 2'h0},
        '{12'h498, 16'hFFFF, 16'h0FFF, 2'h0}, '{12'h49C, 16'hFFFF, 16'h003F, 2'h0},
        '{12'h4A0, 16'hFFFF, 16'h0210, 2'h0}, '{12'h4B0, 16'h1234, 16'h0000, 2'h2},
        '{12'h48E, 16'h0F00, 16'h0000, 2'h2}};

    blr_ctrl_regs blr_ctrl_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .first_rate_converter_en(en1), .first_rate_converter_err(er1), .second_rate_converter_en(en2),
        .second_rate_converter_err(er2), .sample_stb(stb), .conv_path_in(pin), .conv_path_out(pout),
        .main_in(mi), .tone_in(ti), .main_out(mo), .beeper_on(on), .beeper_atten_db(att),
        .beeper_freq_dhz(fq), .sub_lpf_on(lpf_on), .subwoofer_filter_cutoff_hz(hz),
        .conv_delay_samples(dly), .first_rate_converter_deemph(d1), .second_rate_converter_deemph(d2),
        .first_rate_converter_mute(m1), .second_rate_converter_mute(m2));

    initial forever #5 ref_clk = ~ref_clk;

    task tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [47:0] v, input logic [47:0] e);
        n_compared++;
        if (v !== e) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", nm, e, v);
        end
    endtask
    // Both ready inputs are held high, so every answer is taken at the edge it is seen
    task wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] rr);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        rr = bresp;
        if (n >= 50) begin
            miscompares++;
            stop_test;
        end
    endtask
    task rchk(input logic [11:0] a, input logic [1:0] er, input logic [31:0] e);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        if (n >= 50) begin
            miscompares++;
            stop_test;
        end
        chk("read", {rresp, rdata}, {er, e});
    endtask
    task wrs(input logic [11:0] a, input logic [15:0] d);
        wr(a, d, r);
        tick(2);
    endtask

    initial begin
        tick(20);
        rst_n <= 1'b1;
        tick(3);
        chk("dflt", {on, fq, hz, dly, d1, d2}, {1'b0, 17'h0249F, 9'h064, 12'h001, 2'h3});
        rchk(12'h48C, 2'h0, 32'h0005);
        rchk(12'h490, 2'h0, 32'h0003);
        rchk(12'h498, 2'h0, 32'h0000);
        rchk(12'h49C, 2'h0, 32'h0030);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, r);
            chk("bresp", r, rows[i].r);
            rchk(rows[i].a, rows[i].r, {16'h0000, rows[i].e});
        end
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(3);
        rchk(12'h48C, 2'h0, 32'h0005);
        wrs(12'h48C, 16'h0F01);
        chk("tone", {on, att, fq}, {1'b1, 6'h0A, 17'h00753});
        wrs(12'h48C, 16'h012F);
        chk("tone", {on, att, fq}, {1'b1, 6'h26, 17'h1583D});
        wrs(12'h48C, 16'h0100);
        chk("tone", {on, att, fq}, {1'b0, 6'h26, 17'h00000});
        wrs(12'h48C, 16'h0005);
        chk("tone", {on, att, fq}, {1'b0, 6'h00, 17'h0249F});
        strb <= 4'h1;
        wrs(12'h48C, 16'h0E02);
        rchk(12'h48C, 2'h0, 32'h0002);
        strb <= 4'h2;
        wrs(12'h48C, 16'h0E00);
        rchk(12'h48C, 2'h0, 32'h0E02);
        strb <= 4'h3;
        wrs(12'h490, 16'h000F);
        chk("cut", {lpf_on, hz}, {1'b1, 9'h154});
        wrs(12'h490, 16'h0001);
        chk("cut", {lpf_on, hz}, {1'b1, 9'h03C});
        wrs(12'h490, 16'h0000);
        chk("cut", {lpf_on, hz}, {1'b0, 9'h000});
        wrs(12'h498, 16'h00FF);
        chk("dly", dly, 12'h100);
        wrs(12'h498, 16'h07E1);
        chk("dly", dly, 12'h7E2);
        wrs(12'h498, 16'h0FFF);
        chk("dly", dly, 12'h7E2);
        wrs(12'h498, 16'h0002);
        for (int k = 0; k < 8; k++) begin
            stb <= 1'b1;
            pin <= 24'(k);
            tick(1);
            stb <= 1'b0;
            tick(1);
            chk("path", pout, (k >= 3) ? 24'(k - 3) : 24'h000000);
        end
        en1 <= 1'b1;
        er1 <= 1'b1;
        en2 <= 3'h7;
        er2 <= 3'h7;
        wrs(12'h49C, 16'h0000);
        chk("conv", {d1, d2, m1, m2}, {3'h1, 3'h7});
        wrs(12'h49C, 16'h0038);
        chk("conv", {d1, d2, m1, m2}, {3'h6, 3'h7});
        wrs(12'h49C, 16'h0015);
        chk("conv", {d1, d2, m1, m2}, {3'h3, 3'h2});
        rchk(12'h4A4, 2'h0, 32'h005F);
        er1 <= 1'b0;
        er2 <= 3'h5;
        tick(2);
        chk("mute", {m1, m2}, {1'b0, 3'h0});
        wrs(12'h48C, 16'h0F01);
        mi <= 16'sh0064;
        ti <= 16'sh0005;
        tick(2);
        chk("mix", mo, 16'h0069);
        wrs(12'h4A0, 16'h0200);
        chk("mix", mo, 16'h0005);
        wrs(12'h4A0, 16'h0000);
        mi <= 16'sh7FFF;
        tick(2);
        chk("mix", mo, 16'h7FFF);
        wrs(12'h490, 16'h0003);
        wrs(12'h4A0, 16'h0010);
        chk("lpf", lpf_on, 1'b0);
        stop_test;
    end
endmodule // tb_top
